// File: video_source_pkg.sv
// shared constants, types and helpers for the parallel video source
package video_source_pkg;

    // system clock rate
    localparam int CLK_MHZ = 125;

    // vertical minimums, in line periods
    localparam int VSW_MIN_LINES = 1;
    localparam int VBP_MIN_LINES = 2;
    localparam int VFP_MIN_LINES = 1;
    localparam int TVB_BASE_LINES = 6;
    localparam int TVB_SCALE_LINES = 8;

    // horizontal limits, in pixel clocks
    localparam int HSW_MIN_PCLK = 4;
    localparam int HSW_MAX_PCLK = 128;
    localparam int HBP_MIN_PCLK = 4;
    localparam int HFP_MIN_PCLK = 8;

    // eye-select setup and hold around frame sync changes
    localparam real EYE_SETUP_MS = 1.0;
    localparam real EYE_HOLD_MS = 1.0;
    localparam int EYE_SETUP_CYC = int'($ceil(EYE_SETUP_MS * 1000.0 * CLK_MHZ));
    localparam int EYE_HOLD_CYC = int'($ceil(EYE_HOLD_MS * 1000.0 * CLK_MHZ));

    // pixel bus width and default divider (125 MHz / 4 = 32 ns pixel clock)
    localparam int PIXEL_BITS = 24;
    localparam int PCLK_DIV_DEF = 4;

    // pins driven toward the display controller
    typedef struct packed {
        logic frame_sync;
        logic line_sync;
        logic pixel_valid;
        logic [PIXEL_BITS-1:0] pixel_bus;
    } video_pins_s;

    // least total vertical blanking for a given active and display line count
    function automatic int tvb_min(input int src_lines, input int disp_lines);
        int scaled;
        scaled = (TVB_SCALE_LINES * src_lines + disp_lines - 1) / disp_lines;
        if (scaled < TVB_SCALE_LINES) begin
            scaled = TVB_SCALE_LINES;
        end
        return TVB_BASE_LINES + scaled;
    endfunction : tvb_min

endpackage : video_source_pkg

// File: pclk_divider.sv
// pixel clock divider with registered fall and pre-fall ticks
`timescale 1ns/1ps
`default_nettype none

module pclk_divider #(
    parameter int DIV = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic pclk,
    output logic fall_tick,
    output logic pre_tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST_C = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF_C = CW'(DIV / 2);
    localparam logic [CW-1:0] PRE_C = CW'(DIV / 2 - 1);

    logic [CW-1:0] cnt_ff;
    logic pclk_ff;
    logic fall_ff;
    logic pre_ff;
    wire logic [CW-1:0] nxt_cnt;

    if (DIV < 4 || DIV % 2 != 0) begin : g_div_check
        $error("pclk_divider: DIV must be even and at least 4");
    end

    // wrap counter; high half first, low half second
    assign nxt_cnt = (cnt_ff == LAST_C) ? '0 : cnt_ff + 1'b1;

    // pclk and ticks are all registered from the same next count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= LAST_C; // first pclk pulse after reset is full width
            pclk_ff <= 1'b0;
            fall_ff <= 1'b0;
            pre_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pclk_ff <= nxt_cnt < HALF_C;
            fall_ff <= nxt_cnt == HALF_C;
            pre_ff <= nxt_cnt == PRE_C;
        end
    end

    assign pclk = pclk_ff;
    assign fall_tick = fall_ff;
    assign pre_tick = pre_ff;

endmodule : pclk_divider

`default_nettype wire

// File: video_source.sv
// parallel video source: frame and line timing generator driving the display input port
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - frame sync high at least one line
// - two lines from frame sync to first active
// - one line after last active before frame sync
// - total vertical blanking meets scaled minimum
// - line sync high 4 to 128 pixel clocks
// - four clocks from line sync to valid
// - eight clocks from valid fall to sync
// - sync, valid, bus stable around rising edge
// - eye select changes 1 ms before sync
// - eye select held 1 ms after sync
module video_source #(
    parameter int H_ACT = 64,
    parameter int H_SW = 4,
    parameter int H_BP = 8,
    parameter int H_FP = 8,
    parameter int V_ACT = 16,
    parameter int V_SW = 1,
    parameter int V_BP = 7,
    parameter int V_FP = 7,
    parameter int DISP_LINES = 16,
    parameter int PCLK_DIV = video_source_pkg::PCLK_DIV_DEF,
    parameter int EYE_SETUP_CYC = video_source_pkg::EYE_SETUP_CYC,
    parameter int EYE_HOLD_CYC = video_source_pkg::EYE_HOLD_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic RUN,
    input wire logic EYE_REQ,
    input wire logic [video_source_pkg::PIXEL_BITS-1:0] PIX_DATA,
    input wire logic PIX_VALID,
    output logic PIX_READY,
    output logic UNDERFLOW,
    output logic PCLK,
    output logic FRAME_SYNC,
    output logic LINE_SYNC,
    output logic PIXEL_VALID,
    output logic [video_source_pkg::PIXEL_BITS-1:0] PIXEL_BUS,
    output logic STEREO_EYE_SELECT
);
    localparam int H_TOT = H_BP + H_ACT + H_FP;
    localparam int V_TOT = V_BP + V_ACT + V_FP;
    localparam int HW = $clog2(H_TOT + 1);
    localparam int VW = $clog2(V_TOT + 1);
    localparam int EYE_MAX = (EYE_SETUP_CYC > EYE_HOLD_CYC) ? EYE_SETUP_CYC : EYE_HOLD_CYC;
    localparam int TW = $clog2(EYE_MAX + 1);
    localparam int TVB_MIN = video_source_pkg::tvb_min(V_ACT, DISP_LINES);
    localparam logic [HW-1:0] H_LAST = HW'(H_TOT - 1);
    localparam logic [HW-1:0] H_SW_C = HW'(H_SW);
    localparam logic [HW-1:0] H_DE_ON = HW'(H_BP);
    localparam logic [HW-1:0] H_DE_OFF = HW'(H_BP + H_ACT);
    localparam logic [VW-1:0] V_LAST = VW'(V_TOT - 1);
    localparam logic [VW-1:0] V_SW_C = VW'(V_SW);
    localparam logic [VW-1:0] V_ACT_ON = VW'(V_BP);
    localparam logic [VW-1:0] V_ACT_OFF = VW'(V_BP + V_ACT);
    localparam logic [TW-1:0] T_CAP = TW'(EYE_MAX);
    localparam logic [TW-1:0] T_SETUP = TW'(EYE_SETUP_CYC);
    localparam logic [TW-1:0] T_HOLD = TW'(EYE_HOLD_CYC);

    // geometry that would break the receiver's minimums is refused
    if (H_SW < video_source_pkg::HSW_MIN_PCLK || H_SW > video_source_pkg::HSW_MAX_PCLK)
    begin : g_hsw_check
        $error("video_source: H_SW out of range");
    end
    if (H_BP < video_source_pkg::HBP_MIN_PCLK || H_BP < H_SW || H_ACT < 1) begin : g_hbp_check
        $error("video_source: H_BP or H_ACT too small");
    end
    if (H_FP < video_source_pkg::HFP_MIN_PCLK) begin : g_hfp_check
        $error("video_source: H_FP too small");
    end
    if (V_SW < video_source_pkg::VSW_MIN_LINES || V_SW > V_BP || V_ACT < 1) begin : g_vsw_check
        $error("video_source: V_SW or V_ACT out of range");
    end
    if (V_BP < video_source_pkg::VBP_MIN_LINES || V_FP < video_source_pkg::VFP_MIN_LINES)
    begin : g_vporch_check
        $error("video_source: vertical porch too small");
    end
    if (V_BP + V_FP < TVB_MIN || DISP_LINES < 1) begin : g_tvb_check
        $error("video_source: total vertical blanking too small");
    end

    // pixel clock made from the system clock
    wire logic pclk_w;
    wire logic fall_w;
    wire logic pre_w;

    pclk_divider #(
        .DIV(PCLK_DIV)
    ) u_div (
        .clk(CLK),
        .rst_n(RST_N),
        .pclk(pclk_w),
        .fall_tick(fall_w),
        .pre_tick(pre_w)
    );

    logic [HW-1:0] h_ff;
    logic [VW-1:0] v_ff;
    video_source_pkg::video_pins_s pins_ff;
    logic pclk_ff;
    logic eye_ff;
    logic ready_ff;
    logic under_ff;
    logic [TW-1:0] since_vs_ff;
    logic [TW-1:0] since_eye_ff;

    // position decode for the pixel driven at the next fall
    wire logic h_last = h_ff == H_LAST;
    wire logic v_last = v_ff == V_LAST;
    wire logic pos_hs = h_ff < H_SW_C;
    wire logic pos_vs = v_ff < V_SW_C;
    wire logic pos_line = (v_ff >= V_ACT_ON) && (v_ff < V_ACT_OFF);
    wire logic pos_de = pos_line && (h_ff >= H_DE_ON) && (h_ff < H_DE_OFF);
    wire logic take_w = ready_ff && PIX_VALID;

    // a new frame waits in the last blank line until the eye setup is met
    wire logic frame_ok = RUN && (since_eye_ff >= T_SETUP);
    wire logic [HW-1:0] nxt_h = h_last ? '0 : h_ff + 1'b1;
    wire logic [VW-1:0] v_step = v_last ? (frame_ok ? '0 : v_ff) : v_ff + 1'b1;
    wire logic [VW-1:0] nxt_v = h_last ? v_step : v_ff;

    // eye select moves only well clear of frame sync activity
    wire logic eye_quiet = !pins_ff.frame_sync && !pos_vs && !v_last;
    wire logic eye_chg = (EYE_REQ != eye_ff) && eye_quiet && (since_vs_ff >= T_HOLD);

    // pin values for the next fall; the bus only carries a pixel during valid
    video_source_pkg::video_pins_s nxt_pins;
    assign nxt_pins.frame_sync = pos_vs;
    assign nxt_pins.line_sync = pos_hs;
    assign nxt_pins.pixel_valid = pos_de;
    assign nxt_pins.pixel_bus = take_w ? PIX_DATA : '0;
    wire logic vs_toggle = fall_w && (nxt_pins.frame_sync != pins_ff.frame_sync);

    // raster position advances once per pixel clock
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            h_ff <= '0;
            v_ff <= V_LAST;
        end else if (fall_w) begin
            h_ff <= nxt_h;
            v_ff <= nxt_v;
        end
    end

    // pins change only while pclk is low, one cycle after its fall
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pins_ff <= '0;
        end else if (fall_w) begin
            pins_ff <= nxt_pins;
        end
    end

    // pixel handshake toward the user side, plus starved-pixel flag
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ready_ff <= 1'b0;
            under_ff <= 1'b0;
        end else begin
            ready_ff <= pre_w && pos_de;
            under_ff <= ready_ff && !PIX_VALID;
        end
    end

    // retimed pixel clock so the pin comes straight from a flip-flop here
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pclk_ff <= 1'b0;
        end else begin
            pclk_ff <= pclk_w;
        end
    end

    // eye select and the two timers that guard its changes
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            eye_ff <= 1'b0;
            since_eye_ff <= T_CAP;
            since_vs_ff <= T_CAP;
        end else begin
            eye_ff <= eye_chg ? EYE_REQ : eye_ff;
            since_eye_ff <= eye_chg ? '0 : ((since_eye_ff == T_CAP) ? T_CAP : since_eye_ff + 1'b1);
            since_vs_ff <= vs_toggle ? '0 : ((since_vs_ff == T_CAP) ? T_CAP : since_vs_ff + 1'b1);
        end
    end

    assign PIX_READY = ready_ff;
    assign UNDERFLOW = under_ff;
    assign PCLK = pclk_ff;
    assign FRAME_SYNC = pins_ff.frame_sync;
    assign LINE_SYNC = pins_ff.line_sync;
    assign PIXEL_VALID = pins_ff.pixel_valid;
    assign PIXEL_BUS = pins_ff.pixel_bus;
    assign STEREO_EYE_SELECT = eye_ff;

    // helper counters for the checks, stepped with the pins
    logic [15:0] hs_len_ff;
    logic [15:0] hs_age_ff;
    logic [15:0] de_gap_ff;
    logic [15:0] vs_lines_ff;
    logic [15:0] tail_ff;
    logic [15:0] front_ff;
    logic [15:0] de_lines_ff;
    logic de_seen_ff;
    wire logic hs_rise = !pins_ff.line_sync && nxt_pins.line_sync;
    wire logic vs_rise = !pins_ff.frame_sync && nxt_pins.frame_sync;
    wire logic de_rise = !pins_ff.pixel_valid && nxt_pins.pixel_valid;
    wire logic de_fall = pins_ff.pixel_valid && !nxt_pins.pixel_valid;

    // counts in pixel clocks and line periods
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hs_len_ff <= '0;
            hs_age_ff <= '0;
            de_gap_ff <= '0;
            vs_lines_ff <= '0;
            tail_ff <= '0;
            front_ff <= '0;
            de_lines_ff <= '0;
            de_seen_ff <= 1'b0;
        end else if (fall_w) begin
            hs_len_ff <= hs_rise ? 16'h0001 : (nxt_pins.line_sync ? hs_len_ff + 1'b1 : hs_len_ff);
            hs_age_ff <= hs_rise ? 16'h0000 : hs_age_ff + 1'b1;
            de_gap_ff <= de_fall ? 16'h0000 : de_gap_ff + 1'b1;
            vs_lines_ff <= vs_rise ? 16'h0000 : (hs_rise ? vs_lines_ff + 1'b1 : vs_lines_ff);
            tail_ff <= de_fall ? 16'h0000 : (hs_rise ? tail_ff + 1'b1 : tail_ff);
            front_ff <= vs_rise ? tail_ff : front_ff;
            de_lines_ff <= vs_rise ? 16'h0000 : (de_rise ? de_lines_ff + 1'b1 : de_lines_ff);
            de_seen_ff <= de_seen_ff || de_fall;
        end
    end

    sequence s_pins_settled;
        $stable(pins_ff) ##1 $stable(pins_ff);
    endsequence

    sequence s_frame_edge;
        $changed(pins_ff.frame_sync);
    endsequence

    a_vsync_width: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(pins_ff.frame_sync) |-> vs_lines_ff >= 16'(video_source_pkg::VSW_MIN_LINES))
        else $error("frame sync high for less than one line");

    a_back_porch: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(pins_ff.pixel_valid) && de_lines_ff == 16'h0001
        |-> vs_lines_ff >= 16'(video_source_pkg::VBP_MIN_LINES))
        else $error("vertical back porch too short");

    a_front_porch: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(pins_ff.frame_sync) && de_seen_ff
        |-> front_ff >= 16'(video_source_pkg::VFP_MIN_LINES))
        else $error("vertical front porch too short");

    a_total_blank: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(pins_ff.pixel_valid) && de_lines_ff == 16'h0001 && de_seen_ff
        |-> vs_lines_ff + front_ff >= 16'(TVB_MIN))
        else $error("total vertical blanking too short");

    a_hsync_width: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(pins_ff.line_sync) |-> hs_len_ff >= 16'(video_source_pkg::HSW_MIN_PCLK)
        && hs_len_ff <= 16'(video_source_pkg::HSW_MAX_PCLK))
        else $error("line sync width out of range");

    a_hsync_to_valid: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(pins_ff.pixel_valid) |-> hs_age_ff >= 16'(video_source_pkg::HBP_MIN_PCLK))
        else $error("horizontal back porch too short");

    a_valid_to_hsync: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(pins_ff.line_sync) && de_seen_ff
        |-> de_gap_ff >= 16'(video_source_pkg::HFP_MIN_PCLK))
        else $error("horizontal front porch too short");

    a_pins_stable: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(pclk_ff) |-> s_pins_settled)
        else $error("pins moved near the pixel clock rise");

    a_eye_setup: assert property (@(posedge CLK) disable iff (!RST_N)
        s_frame_edge |-> since_eye_ff >= T_SETUP && $stable(eye_ff))
        else $error("eye select changed too close before frame sync");

    a_eye_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        $changed(eye_ff) |-> since_vs_ff >= T_HOLD && !pins_ff.frame_sync)
        else $error("eye select changed too soon after frame sync");

endmodule : video_source

`default_nettype wire

// File: video_sink.sv
// receiving display port model: framing, porch counts, eye timing, pixel capture
`timescale 1ns/1ps
`default_nettype none

module video_sink #(
    parameter int V_ACT = 8,
    parameter int DISP = 8,
    parameter real SETUP_NS = 1.0e6,
    parameter real HOLD_NS = 1.0e6
) (
    input wire logic rst_n,
    input wire logic pclk,
    input wire video_source_pkg::video_pins_s pins,
    input wire logic eye
);
    localparam int RATIO = (8 * V_ACT + DISP - 1) / DISP;
    localparam int TVB_NEED = 6 + (RATIO > 8 ? RATIO : 8);
    logic fs_q = 1'b0, ls_q = 1'b0, dv_q = 1'b0;
    bit synced, seen_fall;
    int h = 0, hsw = 0, fall_h = 0, line = 0, first_act = -1, last_act = 0, vsw = 0;
    int viol = 0, frames = 0, acts = 0, px_line = 0, lines_act = 0;
    realtime fs_t = -1.0e9, eye_t = -1.0e9;
    logic [video_source_pkg::PIXEL_BITS-1:0] got[$];

    // sample the sync, valid and bus pins on the pixel clock rise
    always @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            {fs_q, ls_q, dv_q, synced, seen_fall} = '0;
        end else begin
            h++;
            if (pins.line_sync && !ls_q) begin
                if (seen_fall && h - fall_h < 8) viol++;
                h = 0;
                hsw = 0;
                line++;
                if (pins.frame_sync && !fs_q) begin
                    if (synced && (vsw < 1 || first_act < 2 || line - last_act < 2)) viol++;
                    if (synced && first_act + line - last_act - 1 < TVB_NEED) viol++;
                    if (synced) lines_act = acts;
                    frames++;
                    synced = 1;
                    line = 0;
                    vsw = 0;
                    first_act = -1;
                    acts = 0;
                end
                if (pins.frame_sync) vsw++;
            end
            if (pins.line_sync) hsw++;
            if (!pins.line_sync && ls_q && (hsw < 4 || hsw > 128)) viol++;
            if (pins.pixel_valid && !dv_q) begin
                if (h < 4) viol++;
                if (first_act < 0) first_act = line;
                last_act = line;
                acts++;
                px_line = 0;
            end
            if (!pins.pixel_valid && dv_q) begin
                fall_h = h;
                seen_fall = 1;
            end
            if (pins.pixel_valid) begin
                got.push_back(pins.pixel_bus);
                px_line++;
            end
            {fs_q, ls_q, dv_q} = {pins.frame_sync, pins.line_sync, pins.pixel_valid};
        end
    end

    // eye select must settle before and hold after each frame sync change
    always @(pins.frame_sync) begin
        if (rst_n && $realtime - eye_t < SETUP_NS) viol++;
        fs_t = $realtime;
    end
    always @(eye) begin
        if (rst_n && $realtime - fs_t < HOLD_NS) viol++;
        eye_t = $realtime;
    end
endmodule : video_sink

`default_nettype wire

// File: tb_top.sv
// bench for the parallel video source against the receiving port model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int HA = 16;
    localparam int VA = 8;
    localparam int EC = 200;
    logic CLK = 1'b0, RST_N = 1'b0, RUN = 1'b0, EYE_REQ = 1'b0, PIX_VALID = 1'b0;
    logic [video_source_pkg::PIXEL_BITS-1:0] PIX_DATA = '0, PIXEL_BUS;
    logic PIX_READY, UNDERFLOW, PCLK, FRAME_SYNC, LINE_SYNC, PIXEL_VALID, STEREO_EYE_SELECT;
    video_source_pkg::video_pins_s pins;
    logic [video_source_pkg::PIXEL_BITS-1:0] exp_q[$];
    int mismatches = 0, checks = 0, drops = 0, unders = 0;

    always #4 CLK = ~CLK;
    assign pins = {FRAME_SYNC, LINE_SYNC, PIXEL_VALID, PIXEL_BUS};

    video_source #(.H_ACT(HA), .H_BP(4), .V_ACT(VA), .V_BP(7),
        .V_FP(7), .DISP_LINES(VA), .PCLK_DIV(4), .EYE_SETUP_CYC(EC), .EYE_HOLD_CYC(EC)) dut_u (
        .CLK(CLK), .RST_N(RST_N), .RUN(RUN), .EYE_REQ(EYE_REQ), .PIX_DATA(PIX_DATA),
        .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .UNDERFLOW(UNDERFLOW), .PCLK(PCLK),
        .FRAME_SYNC(FRAME_SYNC), .LINE_SYNC(LINE_SYNC), .PIXEL_VALID(PIXEL_VALID),
        .PIXEL_BUS(PIXEL_BUS), .STEREO_EYE_SELECT(STEREO_EYE_SELECT));

    video_sink #(.V_ACT(VA), .DISP(VA), .SETUP_NS(EC * 8.0), .HOLD_NS(EC * 8.0)) rx_u (
        .rst_n(RST_N), .pclk(PCLK), .pins(pins), .eye(STEREO_EYE_SELECT));

    // random pixels, with a missing one now and then
    always @(negedge CLK) begin
        PIX_DATA <= video_source_pkg::PIXEL_BITS'($urandom);
        PIX_VALID <= ($urandom % 8) != 0;
    end

    // expected stream: user data, or zero when the slot was empty
    always @(posedge CLK) begin
        if (RST_N && PIX_READY === 1'b1) begin
            exp_q.push_back(PIX_VALID ? PIX_DATA : '0);
            drops += !PIX_VALID;
        end
        unders += (RST_N && UNDERFLOW === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_pix(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pix

    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // bounded wait for frame starts seen by the receiver
    task automatic wait_frames(input int n);
        int t;
        t = rx_u.frames + n;
        for (int i = 0; i < 40000 && rx_u.frames < t; i++) begin
            @(negedge CLK);
        end
        if (rx_u.frames < t) begin
            mismatches++;
            results();
        end
    endtask : wait_frames

    // stop frames, let the raster idle, then reset in the blank line
    task automatic idle_reset();
        RUN <= 1'b0;
        repeat (4000) @(negedge CLK);
        RST_N <= 1'b0;
        repeat (12) @(negedge CLK);
        RST_N <= 1'b1;
    endtask : idle_reset

    initial begin
        void'($urandom(32'heb49));
        repeat (12) @(negedge CLK);
        RST_N <= 1'b1;
        repeat (600) @(negedge CLK);
        chk(rx_u.frames, 0);
        RUN <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            EYE_REQ <= 1'($urandom);
            if (k == 3) begin
                RUN <= 1'b0;
                repeat (500 + $urandom % 3000) @(negedge CLK);
                RUN <= 1'b1;
            end
            wait_frames(1);
            wait_frames(1);
            chk(STEREO_EYE_SELECT, EYE_REQ);
        end
        EYE_REQ <= 1'b0;
        wait_frames(2);
        chk(STEREO_EYE_SELECT, 0);
        idle_reset();
        RUN <= 1'b1;
        wait_frames(3);
        RUN <= 1'b0;
        repeat (4000) @(negedge CLK);
        chk(rx_u.viol, 0);
        chk(rx_u.lines_act, VA);
        chk(rx_u.px_line, HA);
        chk(unders, drops);
        chk(rx_u.got.size(), exp_q.size());
        for (int i = 0; i < exp_q.size() && i < rx_u.got.size(); i++) begin
            chk_pix(rx_u.got[i], exp_q[i]);
        end
        results();
    end
endmodule : tb_top

`default_nettype wire
